// ### common/isptac_pkg.sv
// Constants and types shared by the flash programming control block.
`default_nettype none
package isptac_pkg;
   // Printed register offsets are register indices; byte address is 4x.
   localparam logic [9:0] IDX_ADDR_LOW = 10'h0E4;
   localparam logic [9:0] IDX_ADDR_HIGH = 10'h0E5;
   localparam logic [9:0] IDX_DATA_PORT = 10'h0E6;
   localparam logic [9:0] IDX_OP_CONTROL = 10'h0E7;
   localparam logic [9:0] IDX_KEY = 10'h0EE;
   localparam logic [9:0] IDX_ISP_CONTROL = 10'h0EF;
   localparam int ADDR_W = 12;

   // Timed access key values and window lengths in machine cycles.
   localparam logic [7:0] KEY_FIRST = 8'hAA;
   localparam logic [7:0] KEY_SECOND = 8'h55;
   localparam int KEY_WAIT_MC = 3;
   localparam int WINDOW_MC = 3;
   localparam int CLKS_PER_MC = 1;
   localparam logic [1:0] KEY_WAIT_CYCLES = 2'(KEY_WAIT_MC * CLKS_PER_MC);
   localparam logic [1:0] WINDOW_CYCLES = 2'(WINDOW_MC * CLKS_PER_MC);
   localparam logic [2:0] SWRST_CYCLES = 3'h4;

   // Field positions of the programming-control register.
   localparam int ISP_EN_BIT = 0;
   localparam int BOOT_SEL_BIT = 1;
   localparam int RUN_BANK_BIT = 5;
   localparam int DEV_RST_BIT = 7;

   // Field positions of the flash operation control byte.
   localparam int OP_BANK_BIT = 6;
   localparam int OP_OE_BIT = 5;
   localparam int OP_CE_BIT = 4;
   localparam logic [3:0] CODE_ERASE = 4'h2;
   localparam logic [3:0] CODE_PROGRAM = 4'h1;
   localparam logic [3:0] CODE_READ = 4'h0;

   localparam int APP_BANK_BYTES = 65536;
   localparam int LDR_BANK_BYTES = 4096;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [6:0] OP_CONTROL_RST = 7'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} isptac_seq_state_t;
endpackage
`default_nettype wire

// ### rtl/isptac_ctrl.sv
// Timed-access guarded in-system flash programming control with AXI4-Lite.
`default_nettype none
`timescale 1ns/100ps
module isptac_ctrl #(
   parameter int FLASH_AW = 16,
   parameter int LDR_AW = 12
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [isptac_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [isptac_pkg::ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_cpu_idle,
   input wire logic i_wake,
   output logic o_cpu_rst,
   output logic o_pc_clear,
   output logic o_fetch_loader,
   output logic o_isp_mode,
   output logic o_flash_busy,
   output logic o_fl_erase,
   output logic o_fl_prog,
   output logic o_fl_read,
   output logic o_fl_bank,
   output logic [FLASH_AW-1:0] o_fl_addr,
   output logic [7:0] o_fl_wdata,
   input wire logic i_fl_done,
   input wire logic [7:0] i_fl_rdata
);
   typedef struct packed {
      logic [1:0] key_cnt;
      logic [1:0] win_cnt;
      logic isp_en;
      logic boot_sel;
      logic dev_rst;
      logic run_ldr;
      logic [2:0] rst_cnt;
      logic cpu_rst;
      logic [6:0] op_ctl;
      logic [7:0] addr_hi;
      logic [7:0] addr_lo;
      logic [7:0] fdata;
      logic idle_q;
      logic pc_clr;
      logic start;
   } isptac_core_t;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [isptac_pkg::ADDR_W-1:0] awaddr;
      logic [7:0] wdata;
      logic wlane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } isptac_bus_t;

   typedef struct packed {
      isptac_core_t core;
      isptac_bus_t bus;
   } isptac_state_t;

   isptac_state_t st;
   isptac_state_t next_st;
   logic seq_rd_valid;
   logic [7:0] seq_rd_data;
   logic seq_busy;
   logic wr_fire;
   logic [9:0] wr_idx;
   logic [9:0] rd_idx;
   logic [7:0] wd;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic isp_wr;
   logic key_wr;

   always_comb begin
      next_st = st;
      next_st.core.pc_clr = 1'b0;
      next_st.core.start = 1'b0;
      wr_fire = st.bus.aw_got && st.bus.w_got && !st.bus.bvalid;
      wr_idx = st.bus.awaddr[isptac_pkg::ADDR_W-1:2];
      rd_idx = i_araddr[isptac_pkg::ADDR_W-1:2];
      wd = st.bus.wdata;
      isp_wr = wr_fire && st.bus.wlane0 && (wr_idx == isptac_pkg::IDX_ISP_CONTROL);
      key_wr = wr_fire && st.bus.wlane0 && (wr_idx == isptac_pkg::IDX_KEY);

      // Both counters run down every cycle; zero means closed.
      if (st.core.key_cnt != 2'h0) begin
         next_st.core.key_cnt = st.core.key_cnt - 2'h1;
      end
      if (st.core.win_cnt != 2'h0) begin
         next_st.core.win_cnt = st.core.win_cnt - 2'h1;
      end

      // Write channel: address and data are caught independently.
      if (st.bus.awready && i_awvalid) begin
         next_st.bus.aw_got = 1'b1;
         next_st.bus.awaddr = i_awaddr;
      end
      if (st.bus.wready && i_wvalid) begin
         next_st.bus.w_got = 1'b1;
         next_st.bus.wdata = i_wdata[7:0];
         next_st.bus.wlane0 = i_wstrb[0];
      end
      if (st.bus.bvalid && i_bready) begin
         next_st.bus.bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_st.bus.aw_got = 1'b0;
         next_st.bus.w_got = 1'b0;
         next_st.bus.bvalid = 1'b1;
         next_st.bus.bresp = isptac_pkg::RESP_OKAY;
         unique case (wr_idx)
            isptac_pkg::IDX_ADDR_LOW,
            isptac_pkg::IDX_ADDR_HIGH,
            isptac_pkg::IDX_DATA_PORT,
            isptac_pkg::IDX_OP_CONTROL,
            isptac_pkg::IDX_KEY,
            isptac_pkg::IDX_ISP_CONTROL: next_st.bus.bresp = isptac_pkg::RESP_OKAY;
            default: next_st.bus.bresp = isptac_pkg::RESP_SLVERR;
         endcase
         // A write with lane 0 disabled is answered but stores nothing.
         if (st.bus.wlane0) begin
            unique case (wr_idx)
               isptac_pkg::IDX_ADDR_LOW: next_st.core.addr_lo = wd;
               isptac_pkg::IDX_ADDR_HIGH: next_st.core.addr_hi = wd;
               isptac_pkg::IDX_DATA_PORT: next_st.core.fdata = wd;
               isptac_pkg::IDX_OP_CONTROL: next_st.core.op_ctl = wd[6:0];
               isptac_pkg::IDX_KEY: begin
                  if (wd == isptac_pkg::KEY_FIRST) begin
                     next_st.core.key_cnt = isptac_pkg::KEY_WAIT_CYCLES;
                  end else if (wd == isptac_pkg::KEY_SECOND) begin
                     // A late second key finds the counter at zero.
                     if (st.core.key_cnt != 2'h0) begin
                        next_st.core.win_cnt = isptac_pkg::WINDOW_CYCLES;
                     end
                     next_st.core.key_cnt = 2'h0;
                  end else begin
                     next_st.core.key_cnt = 2'h0;
                     next_st.core.win_cnt = 2'h0;
                  end
               end
               isptac_pkg::IDX_ISP_CONTROL: begin
                  if (st.core.win_cnt != 2'h0) begin
                     next_st.core.isp_en = wd[isptac_pkg::ISP_EN_BIT];
                     next_st.core.boot_sel = wd[isptac_pkg::BOOT_SEL_BIT];
                     if (wd[isptac_pkg::DEV_RST_BIT]) begin
                        next_st.core.dev_rst = 1'b1;
                        next_st.core.rst_cnt = isptac_pkg::SWRST_CYCLES;
                     end
                  end
               end
               default: next_st.core.addr_lo = st.core.addr_lo;
            endcase
         end
      end
      next_st.bus.awready = !next_st.bus.aw_got && !next_st.bus.bvalid;
      next_st.bus.wready = !next_st.bus.w_got && !next_st.bus.bvalid;

      // Read channel answers one cycle after the address is taken.
      rd_hit = 1'b1;
      unique case (rd_idx)
         isptac_pkg::IDX_ADDR_LOW: rd_byte = st.core.addr_lo;
         isptac_pkg::IDX_ADDR_HIGH: rd_byte = st.core.addr_hi;
         isptac_pkg::IDX_DATA_PORT: rd_byte = st.core.fdata;
         isptac_pkg::IDX_OP_CONTROL: rd_byte = {1'b0, st.core.op_ctl};
         isptac_pkg::IDX_KEY: rd_byte = isptac_pkg::BYTE_RST;
         isptac_pkg::IDX_ISP_CONTROL: begin
            rd_byte = isptac_pkg::BYTE_RST;
            rd_byte[isptac_pkg::DEV_RST_BIT] = st.core.dev_rst;
            rd_byte[isptac_pkg::RUN_BANK_BIT] = st.core.run_ldr;
            rd_byte[isptac_pkg::BOOT_SEL_BIT] = st.core.boot_sel;
            rd_byte[isptac_pkg::ISP_EN_BIT] = st.core.isp_en;
         end
         default: begin
            rd_byte = isptac_pkg::BYTE_RST;
            rd_hit = 1'b0;
         end
      endcase
      if (st.bus.rvalid && i_rready) begin
         next_st.bus.rvalid = 1'b0;
      end
      if (st.bus.arready && i_arvalid) begin
         next_st.bus.rvalid = 1'b1;
         next_st.bus.rdata = {24'h000000, rd_byte};
         next_st.bus.rresp = rd_hit ? isptac_pkg::RESP_OKAY : isptac_pkg::RESP_SLVERR;
      end
      next_st.bus.arready = !next_st.bus.rvalid && !(st.bus.arready && i_arvalid);

      // Flash ops start when the core drops into idle with IN_SYSTEM_PROGRAMMING enabled.
      next_st.core.idle_q = i_cpu_idle;
      if (st.core.isp_en && i_cpu_idle && !st.core.idle_q && !seq_busy) begin
         next_st.core.start = 1'b1;
      end
      if (seq_rd_valid) begin
         next_st.core.fdata = seq_rd_data;
      end

      // Switch to the loader bank happens only at a wake-up, never mid-instruction.
      if (i_wake && (st.core.isp_en || st.core.boot_sel) && !st.core.run_ldr) begin
         next_st.core.run_ldr = 1'b1;
         next_st.core.pc_clr = 1'b1;
      end

      // Reset sequence returns every core register, bank included, to reset; bus and sequencer state are kept.
      if (st.core.rst_cnt != 3'h0) begin
         next_st.core.rst_cnt = st.core.rst_cnt - 3'h1;
         if (st.core.rst_cnt == 3'h1) begin
            next_st.core = '0;
         end
      end
      next_st.core.cpu_rst = (next_st.core.rst_cnt != 3'h0);
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   isptac_flash_seq #(
      .AW(FLASH_AW),
      .LDR_AW(LDR_AW)
   ) isptac_flash_seq_inst (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_start(st.core.start),
      .i_op(st.core.op_ctl),
      .i_addr({st.core.addr_hi, st.core.addr_lo}),
      .i_wdata(st.core.fdata),
      .i_fl_done(i_fl_done),
      .i_fl_rdata(i_fl_rdata),
      .o_fl_erase(o_fl_erase),
      .o_fl_prog(o_fl_prog),
      .o_fl_read(o_fl_read),
      .o_fl_bank(o_fl_bank),
      .o_fl_addr(o_fl_addr),
      .o_fl_wdata(o_fl_wdata),
      .o_busy(seq_busy),
      .o_rd_valid(seq_rd_valid),
      .o_rd_data(seq_rd_data)
   );

   assign o_awready = st.bus.awready;
   assign o_wready = st.bus.wready;
   assign o_bvalid = st.bus.bvalid;
   assign o_bresp = st.bus.bresp;
   assign o_arready = st.bus.arready;
   assign o_rvalid = st.bus.rvalid;
   assign o_rresp = st.bus.rresp;
   assign o_rdata = st.bus.rdata;
   assign o_cpu_rst = st.core.cpu_rst;
   assign o_pc_clear = st.core.pc_clr;
   assign o_fetch_loader = st.core.run_ldr;
   assign o_isp_mode = st.core.isp_en;
   assign o_flash_busy = seq_busy;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   sequence s_key_armed;
      key_wr && st.bus.wdata == 8'h55 && st.core.key_cnt != 2'h0;
   endsequence
   sequence s_quiet3;
      (!key_wr)[*3];
   endsequence

   chk_key_opens: assert property (s_key_armed |=> st.core.win_cnt == 2'h3)
      else $error("armed second key did not open window");
   chk_window_len: assert property (
      ($rose(st.core.win_cnt != 2'h0) ##0 s_quiet3) |=> st.core.win_cnt == 2'h0)
      else $error("window not closed after three cycles");
   chk_closed_drop: assert property (
      (isp_wr && st.core.win_cnt == 2'h0) |=> $stable(st.core.isp_en)
      && $stable(st.core.boot_sel) && $stable(st.core.dev_rst))
      else $error("protected bit changed with window closed");
   chk_late_key: assert property (
      (key_wr && st.bus.wdata == 8'h55 && st.core.key_cnt == 2'h0)
      |=> st.core.win_cnt != 2'h3)
      else $error("late second key opened window");
   chk_bad_key: assert property (
      (key_wr && st.bus.wdata != 8'hAA && st.bus.wdata != 8'h55)
      |=> st.core.win_cnt == 2'h0 && st.core.key_cnt == 2'h0)
      else $error("wrong key left write permission");
   chk_open_write: assert property (
      (wr_fire && st.bus.wlane0 && wr_idx == 10'h0E5 && st.core.rst_cnt == 3'h0)
      |=> st.core.addr_hi == $past(st.bus.wdata))
      else $error("unprotected register write lost");
   chk_wake_switch: assert property (
      (i_wake && st.core.isp_en && !st.core.run_ldr && st.core.rst_cnt == 3'h0)
      |=> o_pc_clear && o_fetch_loader ##1 !o_pc_clear)
      else $error("bank switch without single program counter clear");
   chk_soft_reset: assert property (
      (isp_wr && st.core.win_cnt != 2'h0 && st.bus.wdata == 8'h83)
      |=> o_cpu_rst[*4] ##1 (!o_cpu_rst && !st.core.dev_rst && !o_fetch_loader))
      else $error("software reset pulse wrong");
   chk_idle_start: assert property (
      (st.core.isp_en && i_cpu_idle && !st.core.idle_q && !seq_busy
       && st.core.rst_cnt == 3'h0) |=> st.core.start)
      else $error("idle entry did not start flash operation");
   chk_bresp_hold: assert property (
      (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before taken");
endmodule // isptac_ctrl
`default_nettype wire

// ### rtl/isptac_flash_seq.sv
// Flash array operation sequencer: decodes the control byte and runs one op.
`default_nettype none
`timescale 1ns/100ps
module isptac_flash_seq #(
   parameter int AW = 16,
   parameter int LDR_AW = 12
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_start,
   input wire logic [6:0] i_op,
   input wire logic [AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_fl_done,
   input wire logic [7:0] i_fl_rdata,
   output logic o_fl_erase,
   output logic o_fl_prog,
   output logic o_fl_read,
   output logic o_fl_bank,
   output logic [AW-1:0] o_fl_addr,
   output logic [7:0] o_fl_wdata,
   output logic o_busy,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data
);
   typedef struct packed {
      isptac_pkg::isptac_seq_state_t state;
      logic erase;
      logic prog;
      logic rd;
      logic bank;
      logic [AW-1:0] addr;
      logic [7:0] wdata;
      logic rd_valid;
      logic [7:0] rd_data;
   } isptac_seq_t;

   isptac_seq_t st;
   isptac_seq_t next_st;
   logic ce_ok;
   logic oe;
   logic [3:0] code;

   always_comb begin
      next_st = st;
      next_st.rd_valid = 1'b0;
      ce_ok = !i_op[isptac_pkg::OP_CE_BIT];
      oe = i_op[isptac_pkg::OP_OE_BIT];
      code = i_op[3:0];
      unique case (st.state)
         isptac_pkg::SEQ_IDLE: begin
            if (i_start) begin
               next_st.bank = i_op[isptac_pkg::OP_BANK_BIT];
               // Loader bank only decodes its low address bits.
               if (i_op[isptac_pkg::OP_BANK_BIT]) begin
                  next_st.addr = {{(AW-LDR_AW){1'b0}},
                     i_addr[LDR_AW-1:0]};
               end else begin
                  next_st.addr = i_addr;
               end
               next_st.wdata = i_wdata;
               next_st.erase = ce_ok && oe && (code == isptac_pkg::CODE_ERASE);
               next_st.prog = ce_ok && oe && (code == isptac_pkg::CODE_PROGRAM);
               next_st.rd = ce_ok && !oe && (code == isptac_pkg::CODE_READ);
               if (next_st.erase || next_st.prog || next_st.rd) begin
                  next_st.state = isptac_pkg::SEQ_RUN;
               end
            end
         end
         isptac_pkg::SEQ_RUN: begin
            if (i_fl_done) begin
               if (st.rd) begin
                  next_st.rd_valid = 1'b1;
                  next_st.rd_data = i_fl_rdata;
               end
               next_st.erase = 1'b0;
               next_st.prog = 1'b0;
               next_st.rd = 1'b0;
               next_st.state = isptac_pkg::SEQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_fl_erase = st.erase;
   assign o_fl_prog = st.prog;
   assign o_fl_read = st.rd;
   assign o_fl_bank = st.bank;
   assign o_fl_addr = st.addr;
   assign o_fl_wdata = st.wdata;
   assign o_busy = (st.state == isptac_pkg::SEQ_RUN);
   assign o_rd_valid = st.rd_valid;
   assign o_rd_data = st.rd_data;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   chk_seq_decode: assert property (
      (st.state == isptac_pkg::SEQ_IDLE && i_start && !i_op[4] && i_op[5]
       && i_op[3:0] == 4'h1) |=> o_fl_prog && !o_fl_erase && !o_fl_read)
      else $error("program code did not raise program strobe");
   chk_loader_mask: assert property (
      o_fl_bank |-> (o_fl_addr >> LDR_AW) == '0)
      else $error("loader bank address exceeds bank size");
   chk_read_return: assert property (
      (o_fl_read && i_fl_done) |=> o_rd_valid && o_rd_data == $past(i_fl_rdata)
      ##1 !o_rd_valid)
      else $error("read data not returned once");
endmodule // isptac_flash_seq
`default_nettype wire

// ### tb/isptac_ctrl_tb.sv
// Self-checking bench for the timed-access flash programming control.
`default_nettype none
`timescale 1ns/100ps
module isptac_ctrl_tb;
   localparam logic [11:0] A_LO = {isptac_pkg::IDX_ADDR_LOW, 2'b00};
   localparam logic [11:0] A_HI = {isptac_pkg::IDX_ADDR_HIGH, 2'b00};
   localparam logic [11:0] A_DAT = {isptac_pkg::IDX_DATA_PORT, 2'b00};
   localparam logic [11:0] A_OP = {isptac_pkg::IDX_OP_CONTROL, 2'b00};
   localparam logic [11:0] A_KEY = {isptac_pkg::IDX_KEY, 2'b00};
   localparam logic [11:0] A_ISP = {isptac_pkg::IDX_ISP_CONTROL, 2'b00};
   logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, arvalid;
   logic arready, rvalid, idle, wake, cpu_rst, pc_clear, fetch_ldr, isp_mode;
   logic busy, fl_erase, fl_prog, fl_read, fl_bank, fl_done, saw_busy, b;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, lresp;
   logic [15:0] fl_addr;
   logic [7:0] fl_wdata, fl_rdata;
   logic [11:0] qa [3];
   logic [7:0] qd [3];
   int qg [3];
   int n;
   int error_cnt = 0;
   int checked = 0;
   isptac_ctrl isptac_ctrl_inst (
      .i_mclk(mclk), .i_sys_rst(rst), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1),
      .i_cpu_idle(idle), .i_wake(wake), .o_cpu_rst(cpu_rst),
      .o_pc_clear(pc_clear), .o_fetch_loader(fetch_ldr),
      .o_isp_mode(isp_mode), .o_flash_busy(busy), .o_fl_erase(fl_erase),
      .o_fl_prog(fl_prog), .o_fl_read(fl_read), .o_fl_bank(fl_bank),
      .o_fl_addr(fl_addr), .o_fl_wdata(fl_wdata), .i_fl_done(fl_done),
      .i_fl_rdata(fl_rdata));
   isptac_flash_model isptac_flash_model_inst (
      .i_mclk(mclk), .i_erase(fl_erase), .i_prog(fl_prog),
      .i_read(fl_read), .i_bank(fl_bank), .i_addr(fl_addr),
      .i_wdata(fl_wdata), .o_done(fl_done), .o_rdata(fl_rdata));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // The next write is offered at the response edge: only that spacing
   // lands key writes inside the three-cycle windows.
   task automatic wseq(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         awaddr <= qa[i];
         wdata <= {24'h000000, qd[i]};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
         end
         lresp = bresp;
         repeat (qg[i]) @(posedge mclk);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      qa[0] = a;
      qd[0] = d;
      qg[0] = 1;
      wseq(1);
   endtask
   task automatic key(input logic [7:0] v, input int g1, input int g2);
      qa = '{A_KEY, A_KEY, A_ISP};
      qd = '{isptac_pkg::KEY_FIRST, isptac_pkg::KEY_SECOND, v};
      qg = '{g1, g2, 1};
      wseq(3);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      chk(rdata, {24'h000000, exp});
      chk(rresp, isptac_pkg::RESP_OKAY);
   endtask
   task automatic op(input logic [7:0] code);
      wr(A_OP, code);
      idle <= 1'b1;
      repeat (4) @(posedge mclk);
      saw_busy = busy;
      for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge mclk);
      chk(busy, 1'b0);
      repeat (2) @(posedge mclk);
      idle <= 1'b0;
      @(posedge mclk);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, arvalid, idle, wake} = 5'h00;
      {awaddr, araddr, wdata} = 56'h0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdc(A_ISP, 8'h00);
      rdc(A_OP, 8'h00);
      wr(A_ISP, 8'h01);
      rdc(A_ISP, 8'h00);
      wr(A_KEY, 8'h12);
      rdc(A_KEY, 8'h00);
      key(8'h01, 1, 0);
      rdc(A_ISP, 8'h00);
      key(8'h01, 0, 1);
      rdc(A_ISP, 8'h00);
      key(8'h01, 0, 0);
      rdc(A_ISP, 8'h01);
      chk(isp_mode, 1'b1);
      wr(12'h000, 8'h11);
      chk(lresp, isptac_pkg::RESP_SLVERR);
      wr(A_HI, 8'h1A);
      wr(A_LO, 8'hBC);
      rdc(A_HI, 8'h1A);
      rdc(A_LO, 8'hBC);
      for (int i = 0; i < 2; i++) begin
         b = i[0];
         wr(A_DAT, 8'h3C ^ 8'(i));
         op({1'b0, b, 2'b10, isptac_pkg::CODE_PROGRAM});
         n = b ? isptac_flash_model_inst.ldr.exists(32'hABC)
               : isptac_flash_model_inst.app.exists(32'h1ABC);
         chk(n, 1);
         wr(A_DAT, 8'h00);
         op({1'b0, b, 2'b00, isptac_pkg::CODE_READ});
         rdc(A_DAT, 8'h3C ^ 8'(i));
         op({1'b0, b, 2'b10, isptac_pkg::CODE_ERASE});
         op({1'b0, b, 2'b00, isptac_pkg::CODE_READ});
         rdc(A_DAT, 8'hFF);
      end
      wake <= 1'b1;
      n = 0;
      repeat (4) begin
         @(posedge mclk);
         wake <= 1'b0;
         if (pc_clear === 1'b1) n++;
      end
      chk(n, 1);
      chk(fetch_ldr, 1'b1);
      rdc(A_ISP, 8'h21);
      key(8'h00, 0, 0);
      chk(isp_mode, 1'b0);
      op({1'b0, 1'b0, 2'b00, isptac_pkg::CODE_READ});
      chk(saw_busy, 1'b0);
      key(8'h83, 0, 0);
      n = 0;
      repeat (10) begin
         @(posedge mclk);
         if (cpu_rst === 1'b1) n++;
      end
      chk(n != 0, 1'b1);
      rdc(A_ISP, 8'h00);
      chk(fetch_ldr, 1'b0);
      rdc(A_HI, 8'h00);
      // Boot select alone must also move fetches to the loader at wake-up.
      key(8'h02, 0, 0);
      wake <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      @(posedge mclk);
      chk(fetch_ldr, 1'b1);
      rdc(A_ISP, 8'h22);
      close_out();
   end
endmodule // isptac_ctrl_tb
`default_nettype wire

// ### tb/isptac_flash_model.sv
// Behavioural model of the application and loader flash arrays.
`default_nettype none
`timescale 1ns/100ps
module isptac_flash_model #(
   parameter int DLY = 3
) (
   input wire logic i_mclk,
   input wire logic i_erase,
   input wire logic i_prog,
   input wire logic i_read,
   input wire logic i_bank,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic o_done,
   output logic [7:0] o_rdata
);
   // Erased cells read as all ones, so a missing entry stands for FF.
   logic [7:0] app [int];
   logic [7:0] ldr [int];
   int cnt = 0;
   int k;
   initial begin
      o_done = 1'b0;
      o_rdata = 8'h5A;
   end
   // Read data is only meaningful with done; it churns otherwise.
   always @(posedge i_mclk) begin
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
      k = i_bank ? int'(i_addr[11:0]) : int'(i_addr);
      if ((i_erase || i_prog || i_read) && !o_done) begin
         cnt <= cnt + 1;
         if (cnt == DLY) begin
            cnt <= 0;
            o_done <= 1'b1;
            if (i_erase && i_bank) ldr.delete();
            else if (i_erase) app.delete();
            else if (i_prog && i_bank) ldr[k] = i_wdata;
            else if (i_prog) app[k] = i_wdata;
            else if (i_bank) o_rdata <= ldr.exists(k) ? ldr[k] : 8'hFF;
            else o_rdata <= app.exists(k) ? app[k] : 8'hFF;
         end
      end
   end
endmodule // isptac_flash_model
`default_nettype wire
